// ---- hw/ccd_decode.sv ----
// Operation
// RL1: 0F 41 moves when overflow clear, one clock, flags untouched.
// RL2: 0F 4A moves when parity set, one clock, flags untouched.
// RL3: 0F 4B moves when parity clear, one clock, flags untouched.
// RL4: 0F 48 moves on sign set, 0F 49 on sign clear, one clock.
// RL5: false move condition keeps destination yet spends the full clock count.
// RL6: register compare 38-3B mod 11: one clock, six flags, no result.
// RL7: memory-operand compare forms complete in one clock.
// RL8: immediate compare via group 80-83 reg 111, s and w honoured, one clock.
// RL9: 0F B0/B1 compare-exchange takes six clocks, updates six flags.
// RL10: 0F C7 reg 001 with memory operand is eight-byte compare-exchange.
// RL11: 0F 3C reads a special internal register in one clock.
// RL12: 0F 3D writes a special internal register in one clock.
// RL13: opcode 99 sign-extends into data register, two clocks, flags kept.
// RL14: opcode 98 sign-extends low accumulator half, three clocks, flags kept.
// RL15: opcode 27 decimal fix after add, two clocks, five flags.
// RL16: opcode 2F decimal fix after subtract, two clocks.
// RL17: FE/FF reg 001 decrement, one clock, carry kept.
`timescale 1ns/1ps
`default_nettype none
`include "ccd_cfg.svh"

module ccd_decode (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    srst_i,
  // instruction from fetch
  input  wire logic                    instr_valid_i,
  input  wire ccd_pkg::ccd_instr_type  instr_i,
  output logic                         ready_o,
  // operands and current flags
  input  wire logic [31:0]             op_a_i,
  input  wire logic [31:0]             op_b_i,
  input  wire logic [31:0]             op_c_i,
  input  wire ccd_pkg::ccd_flags_type  flags_i,
  // completion towards the pipeline
  output logic                         done_o,
  output ccd_pkg::ccd_op_type          op_o,
  output ccd_pkg::ccd_result_type      res_o
);

  function automatic ccd_pkg::ccd_flags_type sub_flags(input logic [31:0] a,
                                                       input logic [31:0] b,
                                                       input logic        wide);
    logic [31:0] x;
    logic [31:0] y;
    logic [32:0] d;
    logic [7:0]  lo;
    ccd_pkg::ccd_flags_type f;
    // byte operands are moved to the top so sign, carry and overflow share one path
    x = wide ? a : {a[7:0], 24'h000000};
    y = wide ? b : {b[7:0], 24'h000000};
    d = {1'b0, x} - {1'b0, y};
    lo = a[7:0] - b[7:0];
    f.of = (x[31] ^ y[31]) & (x[31] ^ d[31]);
    f.sf = d[31];
    f.zf = (d[31:0] == 32'h00000000);
    f.af = a[4] ^ b[4] ^ lo[4];
    f.pf = ~^lo;
    f.cf = d[32];
    return f;
  endfunction

  logic                   accept;
  logic                   last;
  ccd_pkg::ccd_state_type state_reg;
  ccd_pkg::ccd_state_type state_next;
  ccd_pkg::ccd_op_type    op_reg;
  ccd_pkg::ccd_op_type    op_next;
  ccd_pkg::ccd_result_type res_reg;
  ccd_pkg::ccd_result_type res_next;
  logic                   done_reg;
  logic                   done_next;
  logic                   ready_reg;
  logic                   ready_next;
  ccd_pkg::ccd_op_type    dec_op;
  ccd_pkg::ccd_result_type dec_res;
  logic [`CCD_CYC_WIDTH-1:0] dec_cyc;

  assign accept = instr_valid_i & ready_reg;

  // decode and execute
  always_comb begin
    logic        esc;
    logic        wide;
    logic        mem;
    logic [2:0]  rf;
    logic [7:0]  op1;
    logic [7:0]  al;
    logic        lo_fix;
    logic        hi_fix;
    logic [31:0] imm;
    esc = (instr_i.byte0 == `CCD_OP_ESCAPE);
    wide = instr_i.byte0[0];
    mem = (instr_i.modrm[7:6] != `CCD_MOD_REG);
    rf = instr_i.modrm[5:3];
    op1 = instr_i.byte1;
    al = op_a_i[7:0];
    lo_fix = (al[3:0] > 4'h9) | flags_i.af;
    hi_fix = (al > 8'h99) | flags_i.cf;
    imm = (instr_i.byte0[1:0] == 2'b11) ? {{24{op_b_i[7]}}, op_b_i[7:0]} : op_b_i;
    dec_op = ccd_pkg::CCD_ILLEGAL;
    dec_cyc = `CCD_CYC_ILLEGAL;
    dec_res.value = op_a_i;
    dec_res.flags = flags_i;
    dec_res.mask = `CCD_MASK_NONE;
    dec_res.dest_we = 1'b0;
    dec_res.illegal = 1'b0;
    if (esc) begin
      dec_res.value = op_b_i;
      dec_cyc = `CCD_CYC_CMOV;
      // RL5: move condition gates write only
      unique case (op1)
        // RL1: move on no overflow
        `CCD_OP_MOV_NO_OVF: begin
          dec_op = ccd_pkg::CCD_MOVE_NO_OVF;
          dec_res.dest_we = ~flags_i.of;
        end
        // RL2: move on parity even
        `CCD_OP_MOV_PAR_EV: begin
          dec_op = ccd_pkg::CCD_MOVE_PAR_EVEN;
          dec_res.dest_we = flags_i.pf;
        end
        // RL3: move on parity odd
        `CCD_OP_MOV_PAR_OD: begin
          dec_op = ccd_pkg::CCD_MOVE_PAR_ODD;
          dec_res.dest_we = ~flags_i.pf;
        end
        // RL4: move on sign
        `CCD_OP_MOV_NEG: begin
          dec_op = ccd_pkg::CCD_MOVE_NEG;
          dec_res.dest_we = flags_i.sf;
        end
        `CCD_OP_MOV_NONNEG: begin
          dec_op = ccd_pkg::CCD_MOVE_NONNEG;
          dec_res.dest_we = ~flags_i.sf;
        end
        // RL11: special register read
        `CCD_OP_SPEC_RD: begin
          dec_op = ccd_pkg::CCD_SPEC_READ;
          dec_cyc = `CCD_CYC_SPEC;
          dec_res.dest_we = 1'b1;
        end
        // RL12: special register write
        `CCD_OP_SPEC_WR: begin
          dec_op = ccd_pkg::CCD_SPEC_WRITE;
          dec_cyc = `CCD_CYC_SPEC;
        end
        `CCD_OP_IDENT: begin
          dec_op = ccd_pkg::CCD_PROC_IDENTIFY;
          dec_cyc = `CCD_CYC_IDENT;
        end
        // RL10: eight-byte exchange, memory only
        `CCD_OP_XCHG8: begin
          if (mem && rf == `CCD_REG_XCHG8) begin
            dec_op = ccd_pkg::CCD_CMP_EXCH_8B;
            dec_cyc = `CCD_CYC_XCHG8;
          end
        end
        default: begin
          // RL9: compare-exchange, six clocks
          if (op1[7:1] == `CCD_OP_XCHG_HI) begin
            dec_op = ccd_pkg::CCD_CMP_EXCHANGE;
            dec_cyc = `CCD_CYC_XCHG;
            dec_res.flags = sub_flags(op_a_i, op_b_i, op1[0]);
            dec_res.mask = `CCD_MASK_ARITH;
            dec_res.dest_we = dec_res.flags.zf;
            dec_res.value = dec_res.flags.zf ? op_c_i : op_b_i;
          end
        end
      endcase
    end else begin
      dec_cyc = `CCD_CYC_CMP;
      // RL6: register compare sets flags only
      // RL7: memory compare forms, one clock
      if (instr_i.byte0[7:2] == `CCD_OP_CMP_RM_HI) begin
        dec_op = ccd_pkg::CCD_INT_COMPARE;
        dec_res.flags = sub_flags(op_a_i, op_b_i, wide);
        dec_res.mask = `CCD_MASK_ARITH;
      end else if (instr_i.byte0[7:1] == `CCD_OP_CMP_ACC_HI) begin
        dec_op = ccd_pkg::CCD_INT_COMPARE;
        dec_res.flags = sub_flags(op_a_i, op_b_i, wide);
        dec_res.mask = `CCD_MASK_ARITH;
      // RL8: immediate group compare
      end else if (instr_i.byte0[7:2] == `CCD_OP_CMP_IMM_HI && rf == `CCD_REG_CMP_IMM) begin
        dec_op = ccd_pkg::CCD_INT_COMPARE;
        dec_res.flags = sub_flags(op_a_i, imm, wide);
        dec_res.mask = `CCD_MASK_ARITH;
      end else if (instr_i.byte0[7:1] == `CCD_OP_STR_CMP_HI) begin
        dec_op = ccd_pkg::CCD_STR_COMPARE;
        dec_cyc = `CCD_CYC_STR_CMP;
        dec_res.flags = sub_flags(op_a_i, op_b_i, wide);
        dec_res.mask = `CCD_MASK_ARITH;
      // RL17: decrement keeps carry
      end else if (instr_i.byte0[7:1] == `CCD_OP_DEC_HI && rf == `CCD_REG_DEC) begin
        dec_op = ccd_pkg::CCD_DEC_ONE;
        dec_cyc = `CCD_CYC_DEC;
        dec_res.flags = sub_flags(op_b_i, 32'h00000001, wide);
        dec_res.flags.cf = flags_i.cf;
        dec_res.mask = `CCD_MASK_DEC;
        dec_res.dest_we = 1'b1;
        dec_res.value = wide ? op_b_i - 32'h00000001 : {op_b_i[31:8], op_b_i[7:0] - 8'h01};
      end else begin
        unique case (instr_i.byte0)
          // RL13: extend into data register
          `CCD_OP_EXT_DX: begin
            dec_op = ccd_pkg::CCD_EXT_TO_DX;
            dec_cyc = `CCD_CYC_EXT_DX;
            dec_res.value = {32{op_a_i[31]}};
            dec_res.dest_we = 1'b1;
          end
          // RL14: extend accumulator half
          `CCD_OP_EXT_ACC: begin
            dec_op = ccd_pkg::CCD_EXT_ACC;
            dec_cyc = `CCD_CYC_EXT_ACC;
            dec_res.value = {{16{op_a_i[15]}}, op_a_i[15:0]};
            dec_res.dest_we = 1'b1;
          end
          // RL15: decimal fix after add
          `CCD_OP_FIX_ADD: begin
            dec_op = ccd_pkg::CCD_FIX_AFTER_ADD;
            dec_cyc = `CCD_CYC_FIX;
            al = al + (lo_fix ? 8'h06 : 8'h00) + (hi_fix ? 8'h60 : 8'h00);
          end
          // RL16: decimal fix after subtract
          `CCD_OP_FIX_SUB: begin
            dec_op = ccd_pkg::CCD_FIX_AFTER_SUB;
            dec_cyc = `CCD_CYC_FIX;
            al = al - (lo_fix ? 8'h06 : 8'h00) - (hi_fix ? 8'h60 : 8'h00);
          end
          default: begin
            dec_op = ccd_pkg::CCD_ILLEGAL;
          end
        endcase
        if (dec_op == ccd_pkg::CCD_FIX_AFTER_ADD || dec_op == ccd_pkg::CCD_FIX_AFTER_SUB) begin
          dec_res.value = {op_a_i[31:8], al};
          dec_res.dest_we = 1'b1;
          dec_res.mask = `CCD_MASK_FIX;
          dec_res.flags.sf = al[7];
          dec_res.flags.zf = (al == 8'h00);
          dec_res.flags.af = lo_fix;
          dec_res.flags.pf = ~^al;
          dec_res.flags.cf = hi_fix;
        end
      end
    end
    dec_res.illegal = (dec_op == ccd_pkg::CCD_ILLEGAL);
  end

  ccd_cycle_counter #(
    .W (`CCD_CYC_WIDTH)
  ) ccd_cycle_counter_inst (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .load_i  (accept),
    .value_i (dec_cyc),
    .last_o  (last)
  );

  // sequencing: hold the instruction for its clock count
  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    res_next = res_reg;
    done_next = 1'b0;
    ready_next = ready_reg;
    unique case (state_reg)
      ccd_pkg::CCD_IDLE: begin
        if (accept) begin
          state_next = ccd_pkg::CCD_BUSY;
          op_next = dec_op;
          res_next = dec_res;
          ready_next = 1'b0;
        end
      end
      ccd_pkg::CCD_BUSY: begin
        if (last) begin
          state_next = ccd_pkg::CCD_IDLE;
          done_next = 1'b1;
          ready_next = 1'b1;
        end
      end
      default: begin
        state_next = ccd_pkg::CCD_IDLE;
        ready_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_reg <= ccd_pkg::CCD_IDLE;
      op_reg <= ccd_pkg::CCD_NONE;
      res_reg <= '0;
      done_reg <= 1'b0;
      ready_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      res_reg <= res_next;
      done_reg <= done_next;
      ready_reg <= ready_next;
    end
  end

  assign ready_o = ready_reg;
  assign done_o = done_reg;
  assign op_o = op_reg;
  assign res_o = res_reg;

  sequence s_esc(logic [7:0] b1);
    accept && instr_i.byte0 == `CCD_OP_ESCAPE && instr_i.byte1 == b1;
  endsequence

  sequence s_one(logic [7:0] b0);
    accept && instr_i.byte0 == b0;
  endsequence

  sequence s_done_plain;
    done_o && res_o.mask == `CCD_MASK_NONE && !res_o.illegal;
  endsequence

  a_move_no_ovf: assert property (@(posedge clk_i) disable iff (srst_i) // RL1
    s_esc(`CCD_OP_MOV_NO_OVF) |-> ##2 (s_done_plain ##0 (res_o.dest_we == !$past(flags_i.of, 2))))
    else $error("no-overflow move wrong timing or write");

  a_move_par_even: assert property (@(posedge clk_i) disable iff (srst_i) // RL2
    s_esc(`CCD_OP_MOV_PAR_EV) |-> ##1 !done_o
    ##1 (s_done_plain ##0 (res_o.dest_we == $past(flags_i.pf, 2))))
    else $error("parity-even move wrong timing or write");

  a_move_par_odd: assert property (@(posedge clk_i) disable iff (srst_i) // RL3
    s_esc(`CCD_OP_MOV_PAR_OD) |-> ##2 (s_done_plain ##0 (res_o.dest_we != $past(flags_i.pf, 2))))
    else $error("parity-odd move wrong timing or write");

  a_move_sign: assert property (@(posedge clk_i) disable iff (srst_i) // RL4
    s_esc(`CCD_OP_MOV_NEG) |-> ##2 (s_done_plain ##0 (res_o.dest_we == $past(flags_i.sf, 2))))
    else $error("sign move wrong timing or write");

  a_move_false_hold: assert property (@(posedge clk_i) disable iff (srst_i) // RL5
    s_esc(`CCD_OP_MOV_NONNEG) ##0 flags_i.sf |-> ##1 !ready_o ##1 (done_o && !res_o.dest_we))
    else $error("false move wrote destination or ended early");

  a_cmp_reg_flags: assert property (@(posedge clk_i) disable iff (srst_i) // RL6
    accept && instr_i.byte0[7:2] == `CCD_OP_CMP_RM_HI && instr_i.modrm[7:6] == `CCD_MOD_REG
    |-> ##2 done_o && res_o.mask == `CCD_MASK_ARITH && !res_o.dest_we)
    else $error("register compare wrong timing or flags");

  a_xchg_six_clk: assert property (@(posedge clk_i) disable iff (srst_i) // RL9
    accept && instr_i.byte0 == `CCD_OP_ESCAPE && instr_i.byte1[7:1] == `CCD_OP_XCHG_HI
    |-> ##1 (!done_o)[*6] ##1 done_o && res_o.mask == `CCD_MASK_ARITH)
    else $error("compare-exchange not six clocks");

  a_ext_acc_three: assert property (@(posedge clk_i) disable iff (srst_i) // RL14
    s_one(`CCD_OP_EXT_ACC) |-> ##1 (!done_o)[*3] ##1 s_done_plain)
    else $error("accumulator extend not three clocks");

  a_fix_add_two: assert property (@(posedge clk_i) disable iff (srst_i) // RL15
    s_one(`CCD_OP_FIX_ADD) |-> ##1 !done_o ##1 !done_o ##1 done_o && res_o.mask == `CCD_MASK_FIX)
    else $error("decimal fix after add wrong timing or flags");

  a_dec_keep_cf: assert property (@(posedge clk_i) disable iff (srst_i) // RL17
    accept && instr_i.byte0[7:1] == `CCD_OP_DEC_HI && instr_i.modrm[5:3] == `CCD_REG_DEC
    |-> ##2 done_o && res_o.mask == `CCD_MASK_DEC && res_o.flags.cf == $past(flags_i.cf, 2))
    else $error("decrement touched carry or wrong timing");

endmodule

`default_nettype wire

// ---- hw/ccd_cfg.svh ----
`ifndef CCD_CFG_SVH
`define CCD_CFG_SVH

// opcode bytes
`define CCD_OP_ESCAPE      8'h0F
`define CCD_OP_MOV_NO_OVF  8'h41
`define CCD_OP_MOV_PAR_EV  8'h4A
`define CCD_OP_MOV_PAR_OD  8'h4B
`define CCD_OP_MOV_NEG     8'h48
`define CCD_OP_MOV_NONNEG  8'h49
`define CCD_OP_CMP_RM_HI   6'h0E
`define CCD_OP_CMP_ACC_HI  7'h1E
`define CCD_OP_CMP_IMM_HI  6'h20
`define CCD_OP_STR_CMP_HI  7'h53
`define CCD_OP_XCHG_HI     7'h58
`define CCD_OP_XCHG8       8'hC7
`define CCD_OP_IDENT       8'hA2
`define CCD_OP_SPEC_RD     8'h3C
`define CCD_OP_SPEC_WR     8'h3D
`define CCD_OP_EXT_DX      8'h99
`define CCD_OP_EXT_ACC     8'h98
`define CCD_OP_FIX_ADD     8'h27
`define CCD_OP_FIX_SUB     8'h2F
`define CCD_OP_DEC_HI      7'h7F

// modrm fields
`define CCD_MOD_REG        2'h3
`define CCD_REG_CMP_IMM    3'h7
`define CCD_REG_DEC        3'h1
`define CCD_REG_XCHG8      3'h1

// clock counts on a cache hit
`define CCD_CYC_WIDTH      4
`define CCD_CYC_CMOV       4'h1
`define CCD_CYC_CMP        4'h1
`define CCD_CYC_STR_CMP    4'h6
`define CCD_CYC_XCHG       4'h6
`define CCD_CYC_XCHG8      4'h1
`define CCD_CYC_IDENT      4'hC
`define CCD_CYC_SPEC       4'h1
`define CCD_CYC_EXT_DX     4'h2
`define CCD_CYC_EXT_ACC    4'h3
`define CCD_CYC_FIX        4'h2
`define CCD_CYC_DEC        4'h1
`define CCD_CYC_ILLEGAL    4'h1

// flag update masks, order of,sf,zf,af,pf,cf
`define CCD_MASK_NONE      6'h00
`define CCD_MASK_ARITH     6'h3F
`define CCD_MASK_DEC       6'h3E
`define CCD_MASK_FIX       6'h1F

`endif

// ---- hw/ccd_pkg.sv ----
`default_nettype none

package ccd_pkg;

  typedef struct packed {
    logic of;
    logic sf;
    logic zf;
    logic af;
    logic pf;
    logic cf;
  } ccd_flags_type;

  typedef struct packed {
    logic [7:0] byte0;
    logic [7:0] byte1;
    logic [7:0] modrm;
  } ccd_instr_type;

  typedef enum logic [4:0] {
    CCD_NONE          = 5'h00,
    CCD_MOVE_NO_OVF   = 5'h01,
    CCD_MOVE_PAR_EVEN = 5'h02,
    CCD_MOVE_PAR_ODD  = 5'h03,
    CCD_MOVE_NEG      = 5'h04,
    CCD_MOVE_NONNEG   = 5'h05,
    CCD_INT_COMPARE   = 5'h06,
    CCD_STR_COMPARE   = 5'h07,
    CCD_CMP_EXCHANGE  = 5'h08,
    CCD_CMP_EXCH_8B   = 5'h09,
    CCD_PROC_IDENTIFY = 5'h0A,
    CCD_SPEC_READ     = 5'h0B,
    CCD_SPEC_WRITE    = 5'h0C,
    CCD_EXT_TO_DX     = 5'h0D,
    CCD_EXT_ACC       = 5'h0E,
    CCD_FIX_AFTER_ADD = 5'h0F,
    CCD_FIX_AFTER_SUB = 5'h10,
    CCD_DEC_ONE       = 5'h11,
    CCD_ILLEGAL       = 5'h1F
  } ccd_op_type;

  typedef struct packed {
    logic [31:0]   value;
    ccd_flags_type flags;
    logic [5:0]    mask;
    logic          dest_we;
    logic          illegal;
  } ccd_result_type;

  typedef enum logic [1:0] {
    CCD_IDLE = 2'b01,
    CCD_BUSY = 2'b10
  } ccd_state_type;

endpackage

`default_nettype wire

// ---- hw/ccd_cycle_counter.sv ----
`timescale 1ns/1ps
`default_nettype none

module ccd_cycle_counter #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  // control
  input  wire logic         load_i,
  input  wire logic [W-1:0] value_i,
  // status
  output logic              last_o
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  always_comb begin
    count_next = count_reg;
    if (load_i) begin
      count_next = value_i;
    end else if (count_reg != '0) begin
      count_next = count_reg - {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign last_o = (count_reg == {{(W-1){1'b0}}, 1'b1});

endmodule

`default_nettype wire

// ---- testbench/ccd_decode_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module ccd_decode_tb;
  logic                     clk_i = 1'b0;
  logic                     srst_i;
  logic                     instr_valid_i;
  ccd_pkg::ccd_instr_type   instr_i;
  logic                     ready_o;
  logic [31:0]              op_a_i;
  logic [31:0]              op_b_i;
  logic [31:0]              op_c_i;
  ccd_pkg::ccd_flags_type   flags_i;
  logic                     done_o;
  ccd_pkg::ccd_op_type      op_o;
  ccd_pkg::ccd_result_type  res_o;
  int                       fail_count;
  int                       checks;
  int                       cyc_seen;

  ccd_decode ccd_decode_inst (
    .clk_i         (clk_i),
    .srst_i        (srst_i),
    .instr_valid_i (instr_valid_i),
    .instr_i       (instr_i),
    .ready_o       (ready_o),
    .op_a_i        (op_a_i),
    .op_b_i        (op_b_i),
    .op_c_i        (op_c_i),
    .flags_i       (flags_i),
    .done_o        (done_o),
    .op_o          (op_o),
    .res_o         (res_o)
  );

  always #20 clk_i = ~clk_i;

  task automatic chk(input string nm, input logic [40:0] seen, input logic [40:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report;
    if (fail_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // one instruction; with refuse set, junk stays offered while the block is busy
  task automatic run(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] md,
                     input logic [31:0] a, input logic [31:0] b, input logic [31:0] c,
                     input logic [5:0] f, input logic refuse);
    int n;
    @(negedge clk_i);
    instr_valid_i = 1'b1;
    instr_i = '{byte0: b0, byte1: b1, modrm: md};
    op_a_i = a;
    op_b_i = b;
    op_c_i = c;
    flags_i = ccd_pkg::ccd_flags_type'(f);
    @(negedge clk_i);
    n = 1;
    chk("ready_busy", 41'(ready_o), 41'h0);
    if (refuse) begin
      instr_i = '{byte0: 8'hF1, byte1: 8'h00, modrm: 8'h00};
    end else begin
      instr_valid_i = 1'b0;
    end
    while (done_o !== 1'b1 && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    if (refuse) begin
      instr_valid_i = 1'b0;
    end
    cyc_seen = n - 1;
    chk("ready_done", 41'(ready_o), 41'h1);
    @(negedge clk_i);
    chk("done_pulse", 41'(done_o), 41'h0);
  endtask

  task automatic expect_out(input ccd_pkg::ccd_op_type op, input int cyc, input logic [5:0] mask,
                            input logic we, input logic ill);
    chk("op", 41'(op_o), 41'(op));
    chk("cycles", 41'(cyc_seen), 41'(cyc));
    chk("mask", 41'(res_o.mask), 41'(mask));
    chk("dest_we", 41'(res_o.dest_we), 41'(we));
    chk("illegal", 41'(res_o.illegal), 41'(ill));
  endtask

  task automatic t_reset;
    chk("reset_ready", 41'(ready_o), 41'h1);
    chk("reset_done", 41'(done_o), 41'h0);
    chk("reset_op", 41'(op_o), 41'(ccd_pkg::CCD_NONE));
    chk("reset_res", 41'(res_o.value), 41'h0);
    chk("reset_res_ctl", 41'(res_o[13:0]), 41'h0);
  endtask

  // each move tried with its condition true, then false, other flags inverted
  task automatic t_cmov;
    logic [7:0] opc [5] = '{8'h41, 8'h4A, 8'h4B, 8'h48, 8'h49};
    int         pos [5] = '{5, 1, 1, 4, 4};
    logic       tv  [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    ccd_pkg::ccd_op_type ops [5] = '{ccd_pkg::CCD_MOVE_NO_OVF, ccd_pkg::CCD_MOVE_PAR_EVEN,
      ccd_pkg::CCD_MOVE_PAR_ODD, ccd_pkg::CCD_MOVE_NEG, ccd_pkg::CCD_MOVE_NONNEG};
    logic [5:0] f;
    for (int i = 0; i < 5; i++) begin
      for (int k = 0; k < 2; k++) begin
        f = {6{~(tv[i] ^ k[0])}};
        f[pos[i]] = tv[i] ^ k[0];
        run(8'h0F, opc[i], 8'hC1, 32'h11111111, 32'hA5A5_0F0F, 32'h0, f, k[0]);
        expect_out(ops[i], 1, 6'h00, ~k[0], 1'b0);
        if (k == 0) begin
          chk("cmov_value", 41'(res_o.value), 41'h0A5A5_0F0F);
        end
      end
    end
  endtask

  task automatic t_compare;
    run(8'h39, 8'h00, 8'hC1, 32'h5, 32'h5, 32'h0, 6'h00, 1'b0);
    expect_out(ccd_pkg::CCD_INT_COMPARE, 1, 6'h3F, 1'b0, 1'b0);
    chk("cmp_flags", 41'(res_o.flags), 41'h0A);
    run(8'h3B, 8'h00, 8'h05, 32'h9, 32'h3, 32'h0, 6'h00, 1'b0);
    expect_out(ccd_pkg::CCD_INT_COMPARE, 1, 6'h3F, 1'b0, 1'b0);
    run(8'h38, 8'h00, 8'h05, 32'h9, 32'h3, 32'h0, 6'h00, 1'b0);
    expect_out(ccd_pkg::CCD_INT_COMPARE, 1, 6'h3F, 1'b0, 1'b0);
    run(8'h83, 8'h00, 8'hF8, 32'h0, 32'hFF, 32'h0, 6'h00, 1'b0);
    expect_out(ccd_pkg::CCD_INT_COMPARE, 1, 6'h3F, 1'b0, 1'b0);
    chk("cmp_imm_flags", 41'(res_o.flags), 41'h05);
    run(8'h3D, 8'h00, 8'h00, 32'h1, 32'h2, 32'h0, 6'h00, 1'b0);
    expect_out(ccd_pkg::CCD_INT_COMPARE, 1, 6'h3F, 1'b0, 1'b0);
    chk("cmp_acc_flags", 41'(res_o.flags), 41'h17);
    run(8'hA7, 8'h00, 8'h00, 32'h3, 32'h3, 32'h0, 6'h00, 1'b1);
    expect_out(ccd_pkg::CCD_STR_COMPARE, 6, 6'h3F, 1'b0, 1'b0);
    chk("str_cmp_flags", 41'(res_o.flags), 41'h0A);
  endtask

  task automatic t_exchange;
    run(8'h0F, 8'hB1, 8'hC1, 32'h7, 32'h7, 32'h1234, 6'h00, 1'b0);
    expect_out(ccd_pkg::CCD_CMP_EXCHANGE, 6, 6'h3F, 1'b1, 1'b0);
    chk("xchg_value", 41'(res_o.value), 41'h1234);
    chk("xchg_flags", 41'(res_o.flags), 41'h0A);
    run(8'h0F, 8'hB1, 8'h05, 32'h7, 32'h8, 32'h1234, 6'h00, 1'b1);
    expect_out(ccd_pkg::CCD_CMP_EXCHANGE, 6, 6'h3F, 1'b0, 1'b0);
    run(8'h0F, 8'hC7, 8'h08, 32'h0, 32'h0, 32'h0, 6'h00, 1'b0);
    expect_out(ccd_pkg::CCD_CMP_EXCH_8B, 1, 6'h00, 1'b0, 1'b0);
  endtask

  task automatic t_special;
    run(8'h0F, 8'h3C, 8'hC0, 32'h0, 32'h55, 32'h0, 6'h3F, 1'b0);
    expect_out(ccd_pkg::CCD_SPEC_READ, 1, 6'h00, 1'b1, 1'b0);
    run(8'h0F, 8'h3D, 8'hC0, 32'h0, 32'h55, 32'h0, 6'h3F, 1'b0);
    expect_out(ccd_pkg::CCD_SPEC_WRITE, 1, 6'h00, 1'b0, 1'b0);
    run(8'h0F, 8'hA2, 8'h00, 32'h0, 32'h0, 32'h0, 6'h00, 1'b1);
    expect_out(ccd_pkg::CCD_PROC_IDENTIFY, 12, 6'h00, 1'b0, 1'b0);
  endtask

  task automatic t_convert;
    run(8'h99, 8'h00, 8'h00, 32'h8000_8000, 32'h0, 32'h0, 6'h3F, 1'b1);
    expect_out(ccd_pkg::CCD_EXT_TO_DX, 2, 6'h00, 1'b1, 1'b0);
    chk("ext_dx_value", 41'(res_o.value), 41'h0FFFFFFFF);
    run(8'h98, 8'h00, 8'h00, 32'h0000_8000, 32'h0, 32'h0, 6'h3F, 1'b0);
    expect_out(ccd_pkg::CCD_EXT_ACC, 3, 6'h00, 1'b1, 1'b0);
    chk("ext_acc_value", 41'(res_o.value), 41'h0FFFF8000);
  endtask

  task automatic t_decimal;
    run(8'h27, 8'h00, 8'h00, 32'h0F, 32'h0, 32'h0, 6'h00, 1'b0);
    expect_out(ccd_pkg::CCD_FIX_AFTER_ADD, 2, 6'h1F, 1'b1, 1'b0);
    chk("fix_add_al", 41'(res_o.value[7:0]), 41'h15);
    chk("fix_add_flags", 41'(res_o.flags & 6'h1F), 41'h04);
    run(8'h2F, 8'h00, 8'h00, 32'h0F, 32'h0, 32'h0, 6'h00, 1'b1);
    expect_out(ccd_pkg::CCD_FIX_AFTER_SUB, 2, 6'h1F, 1'b1, 1'b0);
    chk("fix_sub_al", 41'(res_o.value[7:0]), 41'h09);
    chk("fix_sub_flags", 41'(res_o.flags), 41'h06);
  endtask

  task automatic t_decrement;
    run(8'hFF, 8'h00, 8'hC8, 32'h0, 32'h1, 32'h0, 6'h01, 1'b0);
    expect_out(ccd_pkg::CCD_DEC_ONE, 1, 6'h3E, 1'b1, 1'b0);
    chk("dec_value", 41'(res_o.value), 41'h0);
    chk("dec_flags", 41'(res_o.flags), 41'h0B);
    run(8'hFE, 8'h00, 8'hC8, 32'h0, 32'h100, 32'h0, 6'h00, 1'b0);
    expect_out(ccd_pkg::CCD_DEC_ONE, 1, 6'h3E, 1'b1, 1'b0);
    chk("dec_byte", 41'(res_o.value[7:0]), 41'hFF);
    chk("dec_byte_flags", 41'(res_o.flags & 6'h3E), 41'h16);
  endtask

  task automatic t_illegal;
    run(8'hF1, 8'h00, 8'h00, 32'h0, 32'h0, 32'h0, 6'h00, 1'b0);
    expect_out(ccd_pkg::CCD_ILLEGAL, 1, 6'h00, 1'b0, 1'b1);
  endtask

  initial begin
    repeat (5000) @(posedge clk_i);
    fail_count++;
    final_report();
  end

  initial begin
    fail_count = 0;
    checks = 0;
    cyc_seen = 0;
    srst_i = 1'b1;
    instr_valid_i = 1'b0;
    instr_i = '{byte0: 8'h00, byte1: 8'h00, modrm: 8'h00};
    op_a_i = 32'h0;
    op_b_i = 32'h0;
    op_c_i = 32'h0;
    flags_i = ccd_pkg::ccd_flags_type'(6'h00);
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    srst_i = 1'b0;
    t_reset();
    t_cmov();
    t_compare();
    t_exchange();
    t_special();
    t_convert();
    t_decimal();
    t_decrement();
    t_illegal();
    final_report();
  end
endmodule

`default_nettype wire
